// ### hw/ctd_top.sv
`timescale 1ns/10ps
`default_nettype none

// Function
// - select 00 floats data outputs; 01 drives the address register
// - select 10 drives error register, or line clock register when addressed
// - select 11 drives the flush counter value
// - special status high when maintenance or line clock register addressed
// - flush active held while a cache flush runs
// - compare miss asserted when presented address not cached
// - latch enable captures address class and gates gp write
// - address strobe assertion loads the address register
// - address strobe negation clears parity latch, enables gp write
// - stretch strobe assertion enables abort and captures write data
// - stretch strobe negation clears flush counter and disables abort
// - update/check select predict, check or generate; never both
// - tag parity over address bits 21:13; prediction uses same function
// - predicted versus stored parity mismatch during check flags parity error
// - memory parity bits 17,16 flag error, enabling abort and/or parity error
// - low byte error sets bit 06, high byte bit 07
// - data valid asserted when valid data is on the bus
// - continue asserted when the transaction completes
// - dma register loads from read bus, drives address when enabled
// - cache writes take address bits 21:13 as tag data
// - direct mapped cache holding 8 kbyte
// - 12-bit flush counter; overflow ends flush active
module ctd_top
  import ctd_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          addr_latch_en_n,
  input  wire logic          addr_strobe_n,
  input  wire logic          stretch_ctl_n,
  input  wire logic [3:0]    transaction_code,
  input  wire logic [1:0]    addr_class,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [15:0]   wr_data_in,
  input  wire logic [AW-1:0] read_bus,
  input  wire logic [1:0]    out_sel,
  input  wire logic          update_n,
  input  wire logic          check,
  input  wire logic          flush_step,
  input  wire logic          flush_start,
  input  wire logic          err_reg_clear,
  input  wire logic          lclk_wr,
  input  wire logic          parity_abort_en,
  input  wire logic          stored_tag_parity,
  input  wire logic [TAG_W-1:0] stored_tag,
  input  wire logic          stored_valid,
  input  wire logic          low_byte_parity_err,
  input  wire logic          high_byte_parity_err,
  input  wire logic          dma_load,
  input  wire logic          dma_oe,
  input  wire logic          data_ready,
  input  wire logic          xfer_done,
  output logic [AW-1:0]      muxed_addr_data_bus_o,
  output logic               muxed_addr_data_bus_oe,
  output logic [TAG_W-1:0]   tag_data,
  output logic               tag_parity_out,
  output logic               predicted_tag_parity,
  output logic               compare_miss,
  output logic               special_addr_status,
  output logic               flush_active,
  output logic [FLUSH_W-1:0] cache_index,
  output logic               gp_wr_n,
  output logic               parity_err_n,
  output logic               abort_n,
  output logic               main_mem_parity_err,
  output logic               cache_ram_wr_n,
  output logic [15:0]        wr_data,
  output logic [15:0]        mem_error_reg,
  output logic [15:0]        line_clock_reg,
  output logic [AW-1:0]      dma_addr,
  output logic               data_valid_n,
  output logic               continue_n,
  output logic               addr_bit0
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // strobes and sequencer controls come from outside the clock domain
  localparam int SW = 13;
  logic [SW-1:0] raw_s;
  logic [SW-1:0] syn;
  logic ale_s, as_s, sc_s, upd_s, chk_s, step_s, fstart_s;
  logic lo_err_s, hi_err_s, dmald_s, drdy_s, done_s, wrgp_s;

  assign raw_s = {~addr_latch_en_n, ~addr_strobe_n, ~stretch_ctl_n,
                  ~update_n, check, flush_step, flush_start,
                  low_byte_parity_err, high_byte_parity_err, dma_load,
                  data_ready, xfer_done, transaction_code == TC_GP_WRITE};

  ctd_sync #(.W(SW)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (raw_s),
    .q       (syn)
  );

  assign {ale_s, as_s, sc_s, upd_s, chk_s, step_s, fstart_s,
          lo_err_s, hi_err_s, dmald_s, drdy_s, done_s, wrgp_s} = syn;

  logic ale_d, as_d, sc_d, step_d;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ale_d  <= 1'b0;
      as_d   <= 1'b0;
      sc_d   <= 1'b0;
      step_d <= 1'b0;
    end else begin
      ale_d  <= ale_s;
      as_d   <= as_s;
      sc_d   <= sc_s;
      step_d <= step_s;
    end
  end

  logic ale_rise, as_rise, as_fall, sc_rise, sc_fall, step_rise;
  assign ale_rise  = ale_s & ~ale_d;
  assign as_rise   = as_s & ~as_d;
  assign as_fall   = ~as_s & as_d;
  assign sc_rise   = sc_s & ~sc_d;
  assign sc_fall   = ~sc_s & sc_d;
  assign step_rise = step_s & ~step_d;

  // ----------------------------------------------------------------
  // parity and special address helpers
  // ----------------------------------------------------------------
  function automatic logic tag_par(input logic [AW-1:0] a);
    tag_par = ^a[TAG_HI:TAG_LO];
  endfunction

  function automatic logic is_special(input logic [AW-1:0] a);
    is_special = (a[21:0] == LCLK_ADDR) || (a[21:0] == MAINT_ADDR);
  endfunction

  // ----------------------------------------------------------------
  // address, class, write data, dma register
  // ----------------------------------------------------------------
  logic [AW-1:0] addr_reg;
  logic [1:0]    class_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_reg <= '0;
    end else if (as_rise) begin
      addr_reg <= addr_in;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      class_reg <= 2'h0;
    end else if (ale_rise) begin
      class_reg <= addr_class;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_data <= 16'h0000;
    end else if (sc_rise) begin
      wr_data <= wr_data_in;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dma_addr <= '0;
    end else if (dmald_s) begin
      dma_addr <= read_bus;
    end
  end

  // dma address takes the lookup path while its enable is up
  logic [AW-1:0] look_addr;
  assign look_addr = dma_oe ? dma_addr : addr_reg;

  // ----------------------------------------------------------------
  // gp write and abort gating
  // ----------------------------------------------------------------
  logic gp_gate, abort_en;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gp_gate <= 1'b0;
    end else if (ale_rise) begin
      gp_gate <= 1'b0;
    end else if (as_fall) begin
      gp_gate <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gp_wr_n <= 1'b1;
    end else begin
      gp_wr_n <= ~(gp_gate & wrgp_s);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      abort_en <= 1'b0;
    end else if (sc_rise) begin
      abort_en <= 1'b1;
    end else if (sc_fall) begin
      abort_en <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // tag parity
  // ----------------------------------------------------------------
  ctd_par_mode_t mode;
  always_comb begin
    unique case ({upd_s, chk_s})
      2'b00:   mode = CTD_PREDICT;
      2'b01:   mode = CTD_CHECK;
      2'b10:   mode = CTD_GENERATE;
      default: mode = CTD_IDLE;
    endcase
  end

  logic pred;
  assign pred = tag_par(look_addr);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      predicted_tag_parity <= 1'b0;
      tag_data             <= '0;
      tag_parity_out       <= 1'b0;
      cache_ram_wr_n       <= 1'b1;
    end else begin
      predicted_tag_parity <= pred;
      tag_data       <= look_addr[TAG_HI:TAG_LO];
      tag_parity_out <= pred;
      cache_ram_wr_n <= (mode != CTD_GENERATE);
    end
  end

  // direct-mapped: one tag per line, no associativity
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      compare_miss <= 1'b1;
    end else begin
      compare_miss <= ~stored_valid ||
                      (stored_tag != look_addr[TAG_HI:TAG_LO]);
    end
  end

  // ----------------------------------------------------------------
  // parity error latch and memory error register
  // ----------------------------------------------------------------
  logic tag_err, mem_err, any_err, perr_latch;
  assign tag_err = (mode == CTD_CHECK) &&
                   (pred != stored_tag_parity);
  assign mem_err = read_bus[MEMPAR_HI_BIT] |
                   read_bus[MEMPAR_LO_BIT];
  assign any_err = tag_err | mem_err | lo_err_s | hi_err_s;

  // a new error wins over the clear on strobe negation
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      perr_latch <= 1'b0;
    end else if (any_err) begin
      perr_latch <= 1'b1;
    end else if (as_fall) begin
      perr_latch <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      main_mem_parity_err <= 1'b0;
      parity_err_n        <= 1'b1;
      abort_n             <= 1'b1;
    end else begin
      main_mem_parity_err <= mem_err;
      parity_err_n <= ~perr_latch;
      abort_n      <= ~(abort_en & perr_latch & parity_abort_en);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_error_reg <= MER_RST;
    end else begin
      if (err_reg_clear && !any_err) begin
        mem_error_reg <= MER_RST;
      end else begin
        if (mem_err || (any_err && parity_abort_en)) begin
          mem_error_reg[MER_ABORT_BIT] <= 1'b1;
        end
        if (lo_err_s) begin
          mem_error_reg[MER_LO_BIT] <= 1'b1;
        end
        if (hi_err_s) begin
          mem_error_reg[MER_HI_BIT] <= 1'b1;
        end
        if (tag_err) begin
          mem_error_reg[MER_TAG_BIT] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_clock_reg <= LCLK_RST;
    end else if (lclk_wr) begin
      line_clock_reg[LCLK_EN_BIT] <= wr_data[LCLK_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // flush counter
  // ----------------------------------------------------------------
  logic [FLUSH_W-1:0] flush_cnt;
  logic               next_wrap;
  assign next_wrap = (flush_cnt == {FLUSH_W{1'b1}});

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flush_cnt <= FLUSH_RST;
    end else if (sc_fall) begin
      flush_cnt <= FLUSH_RST;
    end else if (step_rise && flush_active) begin
      flush_cnt <= flush_cnt + 1'b1;
    end
  end

  // start wins over the overflow that ends a flush
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flush_active <= 1'b0;
    end else if (fstart_s) begin
      flush_active <= 1'b1;
    end else if (step_rise && next_wrap) begin
      flush_active <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // output select and status
  // ----------------------------------------------------------------
  logic lclk_hit;
  assign lclk_hit = (addr_reg[21:0] == LCLK_ADDR);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      muxed_addr_data_bus_o  <= '0;
      muxed_addr_data_bus_oe <= 1'b0;
    end else begin
      muxed_addr_data_bus_oe <= (out_sel != SEL_FLOAT);
      unique case (out_sel)
        SEL_FLOAT: muxed_addr_data_bus_o <= '0;
        SEL_ADDR:  muxed_addr_data_bus_o <= addr_reg;
        SEL_ERR:   muxed_addr_data_bus_o <= lclk_hit ?
                     AW'(line_clock_reg) : AW'(mem_error_reg);
        SEL_FLUSH: muxed_addr_data_bus_o <= AW'(flush_cnt);
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      special_addr_status <= 1'b0;
      cache_index         <= '0;
      addr_bit0           <= 1'b0;
      data_valid_n        <= 1'b1;
      continue_n          <= 1'b1;
    end else begin
      special_addr_status <= is_special(addr_reg);
      cache_index  <= flush_active ? flush_cnt :
                      look_addr[CIDX_HI:CIDX_LO];
      addr_bit0    <= addr_reg[0];
      data_valid_n <= ~drdy_s;
      continue_n   <= ~done_s;
    end
  end

endmodule

`default_nettype wire

// ### hw/ctd_pkg.sv
package ctd_pkg;

  // ----------------------------------------------------------------
  // widths and geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W       = 22;
  localparam int TAG_HI       = 21;
  localparam int TAG_LO       = 13;
  localparam int TAG_W        = TAG_HI - TAG_LO + 1;
  localparam int FLUSH_W      = 12;
  localparam int CACHE_BYTES  = 8192;
  localparam int CIDX_HI      = 12;
  localparam int CIDX_LO      = 1;

  // ----------------------------------------------------------------
  // error register fields and reset values
  // ----------------------------------------------------------------
  localparam int MER_ABORT_BIT = 15;
  localparam int MER_HI_BIT    = 7;
  localparam int MER_LO_BIT    = 6;
  localparam int MER_TAG_BIT   = 5;
  localparam int MEMPAR_HI_BIT = 17;
  localparam int MEMPAR_LO_BIT = 16;
  localparam int LCLK_EN_BIT   = 6;
  localparam logic [15:0] MER_RST  = 16'h0000;
  localparam logic [15:0] LCLK_RST = 16'h0000;
  localparam logic [FLUSH_W-1:0] FLUSH_RST = 12'h000;

  // ----------------------------------------------------------------
  // special addresses (low 22 bits of the i/o page)
  // ----------------------------------------------------------------
  localparam logic [21:0] LCLK_ADDR  = 22'h3fff66;
  localparam logic [21:0] MAINT_ADDR = 22'h3fffe8;

  // ----------------------------------------------------------------
  // select codes, tag parity modes, transaction codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_FLOAT = 2'h0;
  localparam logic [1:0] SEL_ADDR  = 2'h1;
  localparam logic [1:0] SEL_ERR   = 2'h2;
  localparam logic [1:0] SEL_FLUSH = 2'h3;
  localparam logic [3:0] TC_GP_WRITE = 4'h6;

  typedef enum logic [3:0] {
    CTD_PREDICT  = 4'b0001,
    CTD_CHECK    = 4'b0010,
    CTD_GENERATE = 4'b0100,
    CTD_IDLE     = 4'b1000
  } ctd_par_mode_t;

endpackage

// ### hw/ctd_sync.sv
`timescale 1ns/10ps
`default_nettype none

module ctd_sync
  import ctd_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // the first stage feeds only the second
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

// ### testbench/ctd_top_sva.sv
`timescale 1ns/10ps
`default_nettype none

module ctd_top_sva
  import ctd_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic [1:0]         out_sel,
  input wire logic [AW-1:0]      muxed_addr_data_bus_o,
  input wire logic               muxed_addr_data_bus_oe,
  input wire logic [TAG_W-1:0]   tag_data,
  input wire logic               predicted_tag_parity,
  input wire logic               special_addr_status,
  input wire logic               update_n,
  input wire logic               check,
  input wire logic               cache_ram_wr_n,
  input wire logic               flush_start,
  input wire logic               flush_active,
  input wire logic [FLUSH_W-1:0] cache_index,
  input wire logic [AW-1:0]      read_bus,
  input wire logic               main_mem_parity_err,
  input wire logic               stretch_ctl_n,
  input wire logic               abort_n,
  input wire logic               low_byte_parity_err,
  input wire logic [15:0]        mem_error_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ------------------------------------------
  // held conditions
  // ------------------------------------------
  sequence sel_held(logic [1:0] s);
    (out_sel == s)[*3];
  endsequence
  // three steady cycles cover the registered output stage
  sequence addr_shown;
    (out_sel == SEL_ADDR && muxed_addr_data_bus_oe
     && $stable(muxed_addr_data_bus_o))[*3];
  endsequence

  // ------------------------------------------
  // properties
  // ------------------------------------------
  float_sel_a: assert property (
    sel_held(SEL_FLOAT) |-> !muxed_addr_data_bus_oe)
    else $error("bus driven under float select");
  drive_sel_a: assert property (
    (out_sel != SEL_FLOAT)[*3] |-> muxed_addr_data_bus_oe)
    else $error("bus floated under drive select");
  special_addr_a: assert property (
    addr_shown |-> special_addr_status ==
      (muxed_addr_data_bus_o == LCLK_ADDR
       || muxed_addr_data_bus_o == MAINT_ADDR))
    else $error("special status wrong");
  tag_predict_a: assert property (
    (!flush_active && $stable(tag_data))[*3]
      |-> predicted_tag_parity == ^tag_data)
    else $error("predicted parity wrong");
  both_modes_a: assert property (
    (!update_n && check)[*5] |-> cache_ram_wr_n)
    else $error("ram write with both modes");
  flush_begin_a: assert property (
    $rose(flush_start) && !flush_active |-> ##[1:8] flush_active)
    else $error("flush did not start");
  flush_step_a: assert property (
    flush_active && $past(flush_active) && cache_index != 12'h000
      && cache_index != $past(cache_index)
      |-> cache_index == $past(cache_index) + 12'h001)
    else $error("flush count jumped");
  mem_parity_a: assert property (
    (read_bus[MEMPAR_HI_BIT] || read_bus[MEMPAR_LO_BIT])[*3]
      |-> main_mem_parity_err)
    else $error("memory parity missed");
  abort_window_a: assert property (
    stretch_ctl_n[*8] |-> abort_n)
    else $error("abort outside window");
  low_byte_a: assert property (
    $rose(low_byte_parity_err) |-> ##[1:8] mem_error_reg[MER_LO_BIT])
    else $error("low byte error not logged");
endmodule

bind ctd_top ctd_top_sva #(.AW(AW)) i_ctd_sva (
  .clk(clk), .sys_rst(sys_rst), .out_sel(out_sel),
  .muxed_addr_data_bus_o(muxed_addr_data_bus_o),
  .muxed_addr_data_bus_oe(muxed_addr_data_bus_oe), .tag_data(tag_data),
  .predicted_tag_parity(predicted_tag_parity),
  .special_addr_status(special_addr_status), .update_n(update_n),
  .check(check), .cache_ram_wr_n(cache_ram_wr_n),
  .flush_start(flush_start), .flush_active(flush_active),
  .cache_index(cache_index), .read_bus(read_bus),
  .main_mem_parity_err(main_mem_parity_err),
  .stretch_ctl_n(stretch_ctl_n), .abort_n(abort_n),
  .low_byte_parity_err(low_byte_parity_err), .mem_error_reg(mem_error_reg)
);

`default_nettype wire

// ### testbench/ctd_seq_model.sv
`timescale 1ns/10ps
`default_nettype none

module ctd_seq_model (
  input  wire logic   clk,
  input  wire logic   sys_rst,
  input  wire logic   flush_active,
  input  wire logic   stretch_ctl_n,
  output logic        flush_step,
  output logic        data_ready,
  output logic        xfer_done,
  output logic [12:0] steps
);
  logic [2:0] ph;

  // slow stepping, 4 high and 4 low: overflow is seen before another step
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph         <= 3'h0;
      flush_step <= 1'b0;
      steps      <= 13'h0000;
    end else begin
      ph <= ph + 3'h1;
      if (flush_active && ph == 3'h7) begin
        flush_step <= 1'b1;
        steps      <= steps + 13'h0001;
      end else if (ph == 3'h3) begin
        flush_step <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_ready <= 1'b0;
      xfer_done  <= 1'b0;
    end else begin
      data_ready <= !stretch_ctl_n;
      xfer_done  <= data_ready && !stretch_ctl_n;
    end
  end
endmodule

`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); \
  end \
end

module testbench
  import ctd_pkg::*;
;
  logic        clk, sys_rst, le_n, as_n, st_n, upd_n, chk, fstart, eclr;
  logic        lwr, aen, spar, sval, lo_e, hi_e, dld, oe, tpo, ppar, miss;
  logic        spec, fact, gpw_n, pe_n, abt_n, mpe, ramw_n, dval_n, done_n;
  logic        a0, fstep, drdy, xdone, doe;
  logic [3:0]  tc;
  logic [1:0]  acls, sel;
  logic [21:0] ain, rb, a, bus, dma;
  logic [15:0] wdi, wd, mer, lcr;
  logic [8:0]  stag, tagd;
  logic [11:0] cidx;
  logic [12:0] steps;
  logic [31:0] seed;
  int          err_count, total_checks, i, n;

  ctd_top i_dut (
    .clk(clk), .sys_rst(sys_rst), .addr_latch_en_n(le_n),
    .addr_strobe_n(as_n), .stretch_ctl_n(st_n), .transaction_code(tc),
    .addr_class(acls), .addr_in(ain), .wr_data_in(wdi), .read_bus(rb),
    .out_sel(sel), .update_n(upd_n), .check(chk), .flush_step(fstep),
    .flush_start(fstart), .err_reg_clear(eclr), .lclk_wr(lwr),
    .parity_abort_en(aen), .stored_tag_parity(spar), .stored_tag(stag),
    .stored_valid(sval), .low_byte_parity_err(lo_e),
    .high_byte_parity_err(hi_e), .dma_load(dld), .dma_oe(doe),
    .data_ready(drdy), .xfer_done(xdone), .muxed_addr_data_bus_o(bus),
    .muxed_addr_data_bus_oe(oe), .tag_data(tagd), .tag_parity_out(tpo),
    .predicted_tag_parity(ppar), .compare_miss(miss),
    .special_addr_status(spec), .flush_active(fact), .cache_index(cidx),
    .gp_wr_n(gpw_n), .parity_err_n(pe_n), .abort_n(abt_n),
    .main_mem_parity_err(mpe), .cache_ram_wr_n(ramw_n), .wr_data(wd),
    .mem_error_reg(mer), .line_clock_reg(lcr), .dma_addr(dma),
    .data_valid_n(dval_n), .continue_n(done_n), .addr_bit0(a0)
  );

  ctd_seq_model i_seq (
    .clk(clk), .sys_rst(sys_rst), .flush_active(fact), .stretch_ctl_n(st_n),
    .flush_step(fstep), .data_ready(drdy), .xfer_done(xdone), .steps(steps)
  );

  // ------------------------------------------
  // helpers
  // ------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic exp_sas(input logic [21:0] x);
    return x == LCLK_ADDR || x == MAINT_ADDR;
  endfunction
  function automatic logic exp_par(input logic [21:0] x);
    return ^x[21:13];
  endfunction

  task automatic wt(input int k);
    repeat (k) @(posedge clk);
  endtask
  // checks land mid-cycle so every edge update has settled
  task automatic smp(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic addr_cycle(input logic [21:0] x, input logic [3:0] c);
    wt(1);
    ain  <= x;
    tc   <= c;
    acls <= seed[1:0];
    le_n <= 1'b0;
    wt(4);
    as_n <= 1'b0;
    wt(6);
    le_n <= 1'b1;
    as_n <= 1'b1;
    wt(6);
  endtask

  task automatic par_case(input logic u, c, p, e);
    wt(1);
    upd_n <= u;
    chk   <= c;
    spar  <= p;
    smp(6);
    `CHK(pe_n, e)
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ------------------------------------------
  // main sequence
  // ------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {le_n, as_n, st_n, upd_n} = 4'hf;
    {chk, fstart, eclr, lwr, aen, spar, sval, lo_e, hi_e, dld, doe} = 11'h000;
    {tc, acls, sel} = 8'h00;
    {ain, rb} = 44'h000;
    wdi = 16'h0000;
    stag = 9'h000;
    err_count = 0;
    total_checks = 0;
    seed = 32'hc7f0;
    wt(8);
    sys_rst <= 1'b0;
    smp(4);
    `CHK({abt_n, pe_n, fact, oe}, 4'hc)
    `CHK({mer, lcr}, {MER_RST, LCLK_RST})
    for (i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      a = (i == 0) ? LCLK_ADDR : (i == 1) ? MAINT_ADDR :
          (i == 2) ? MAINT_ADDR ^ 22'h000001 : seed[21:0];
      addr_cycle(a, i[0] ? TC_GP_WRITE : 4'h3);
      sel <= SEL_ADDR;
      smp(4);
      `CHK({bus, oe, a0}, {a, 1'b1, a[0]})
      `CHK(spec, exp_sas(a))
      `CHK(ppar, exp_par(a))
      `CHK(tagd, a[21:13])
      `CHK(gpw_n, !i[0])
      wt(1);
      sel <= SEL_FLOAT;
      smp(4);
      `CHK(oe, 1'b0)
    end
    par_case(1'b1, 1'b0, !exp_par(a), 1'b1);
    par_case(1'b1, 1'b1, !exp_par(a), 1'b0);
    par_case(1'b1, 1'b0, !exp_par(a), 1'b0);
    addr_cycle(a, 4'h3);
    smp(0);
    `CHK(pe_n, 1'b1)
    par_case(1'b0, 1'b1, !exp_par(a), 1'b1);
    `CHK(ramw_n, 1'b1)
    par_case(1'b0, 1'b0, 1'b0, 1'b1);
    `CHK({tpo, ramw_n}, {exp_par(a), 1'b0})
    par_case(1'b1, 1'b0, exp_par(a), 1'b1);
    wt(1);
    stag <= a[21:13];
    sval <= 1'b1;
    smp(6);
    `CHK(miss, 1'b0)
    wt(1);
    sval <= 1'b0;
    lo_e <= 1'b1;
    smp(6);
    `CHK({miss, mer[MER_LO_BIT]}, 2'b11)
    wt(1);
    lo_e <= 1'b0;
    hi_e <= 1'b1;
    sel  <= SEL_ERR;
    smp(6);
    `CHK(bus[7:6], 2'b11)
    wt(1);
    hi_e <= 1'b0;
    aen  <= 1'b1;
    for (i = 0; i < 2; i++) begin
      // clear latch and register first so the memory error alone acts
      wt(1);
      eclr <= 1'b1;
      addr_cycle(a, 4'h3);
      eclr <= 1'b0;
      wdi  <= {seed[15:7], 1'b1, seed[5:0]};
      st_n <= 1'b0;
      smp(6);
      `CHK(wd, wdi)
      `CHK({dval_n, done_n}, 2'b00)
      `CHK({abt_n, pe_n, mer[MER_ABORT_BIT]}, 3'b110)
      wt(1);
      rb <= i[0] ? 22'h020000 : 22'h010000;
      smp(6);
      `CHK({mpe, mer[MER_ABORT_BIT], abt_n, pe_n}, 4'hc)
      wt(1);
      rb   <= 22'h000000;
      st_n <= 1'b1;
      smp(8);
      `CHK({abt_n, dval_n, done_n}, 3'b111)
      seed = lfsr(seed);
    end
    wt(1);
    lwr <= 1'b1;
    wt(3);
    lwr <= 1'b0;
    addr_cycle(LCLK_ADDR, 4'h3);
    smp(4);
    `CHK({lcr, bus[15:0]}, {16'h0040, 16'h0040})
    wt(1);
    eclr <= 1'b1;
    rb   <= seed[21:0];
    dld  <= 1'b1;
    wt(3);
    eclr <= 1'b0;
    dld  <= 1'b0;
    smp(4);
    `CHK(dma, rb)
    wt(1);
    doe <= 1'b1;
    smp(4);
    `CHK({tagd, ppar}, {dma[21:13], exp_par(dma)})
    wt(1);
    rb     <= 22'h000000;
    doe    <= 1'b0;
    sel    <= SEL_FLUSH;
    fstart <= 1'b1;
    wt(4);
    fstart <= 1'b0;
    for (n = 0; n < 2000 && steps !== 13'h0064; n++) @(negedge clk);
    // a spent wait skips the rest and goes straight to the verdict
    if (n == 2000) begin
      err_count++;
    end else begin
      smp(6);
      `CHK({fact, bus[11:0]}, {1'b1, 12'h064})
      for (n = 0; n < 40000 && fact === 1'b1; n++) @(negedge clk);
      if (n == 40000) begin
        err_count++;
      end else begin
        smp(2);
        `CHK({steps, bus[11:0]}, {13'h1000, 12'h000})
      end
    end
    report_and_stop();
  end
endmodule

`default_nettype wire
